// file: rtr_pkg.sv
// Constants, field layouts and types shared by the rail trim register slice
package rtr_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] REG_NEG_ADJUST   = 8'h03;
    localparam logic [7:0] REG_BIAS_CODE    = 8'h04;
    localparam logic [7:0] REG_IRQ_ENABLE   = 8'h05;
    localparam logic [7:0] REG_IRQ_FLAGS    = 8'h07;

    // ========================================================================
    // Field positions
    localparam int SRC_SEL_BIT      = 7;
    localparam int GATE_TRIM_MSB    = 6;
    localparam int GATE_TRIM_LSB    = 4;
    localparam int NEG_LEVEL_MSB    = 2;
    localparam int NEG_LEVEL_LSB    = 0;
    localparam int OVERTEMP_BIT     = 6;
    localparam int EARLY_WARN_BIT   = 5;
    localparam int THERM_HOT_BIT    = 4;
    localparam int THERM_COOL_BIT   = 3;
    localparam int UNDERVOLT_BIT    = 2;

    // ========================================================================
    // Reset values, masks and codes
    localparam logic [2:0] GATE_TRIM_RESET  = 3'h2;
    localparam logic [2:0] GATE_TRIM_MAX    = 3'h4;
    localparam logic [2:0] NEG_LEVEL_RESET  = 3'h3;
    localparam logic [2:0] NEG_LEVEL_RSVD   = 3'h7;
    localparam logic [7:0] BIAS_CODE_RESET  = 8'h74;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h74;
    localparam logic [7:0] IRQ_FIELD_MASK   = 8'h7C;
    localparam logic [7:0] NEG_ADJUST_MASK  = 8'hF7;

    // ========================================================================
    // Analog scale, for reference by the analog model and software
    localparam int BIAS_FULL_SCALE_MV = 2750;
    localparam int BIAS_STEP_MV       = 11;
    localparam int NEG_LEVEL_BASE_MV  = -15750;
    localparam int NEG_LEVEL_STEP_MV  = 250;

    // ========================================================================
    // Serial interface
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_ACK  = 3'b010,
        ST_SEND = 3'b011,
        ST_MACK = 3'b100
    } rtr_state_type;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_PTR  = 2'b01,
        PH_DATA = 2'b10
    } rtr_phase_type;

endpackage

// file: rtr_pin_sampler.sv
// Registered sample of one serial pin with rise and fall detection
`timescale 1ns/1ps
module rtr_pin_sampler (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic level;
    logic prev;

    // Idle bus level is high
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            level <= 1'b1;
            prev  <= 1'b1;
        end else begin
            level <= pin_i;
            prev  <= level;
        end
    end

    assign level_o = level;
    assign rise_o  = level & ~prev;
    assign fall_o  = ~level & prev;
endmodule // rtr_pin_sampler

// file: rtr_rail_trim_regs.sv
// Rail trim, bias code and thermal interrupt enable registers on I2C
`timescale 1ns/1ps
module rtr_rail_trim_regs
    import rtr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR       = 7'h20,
    parameter logic       BIAS_SRC_RESET = 1'b1
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [7:0] ext_bias_code_i,
    input  wire logic       overtemp_stop_evt_i,
    input  wire logic       early_warn_evt_i,
    input  wire logic       therm_hot_evt_i,
    input  wire logic       therm_cool_evt_i,
    input  wire logic       input_undervolt_evt_i,
    output logic            bias_source_select_o,
    output logic [2:0]      gate_neg_trim_o,
    output logic [2:0]      source_neg_level_o,
    output logic [2:0]      source_pos_level_o,
    output logic [7:0]      backplane_bias_code_o,
    output logic            overtemp_stop_irq_en_o,
    output logic            early_warn_irq_en_o,
    output logic            therm_hot_irq_en_o,
    output logic            therm_cool_irq_en_o,
    output logic            input_undervolt_irq_en_o,
    output logic [7:0]      thermal_irq_flags_o
);
    // ========================================================================
    // Pin sampling
    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;
    logic start_seen, stop_seen;

    rtr_pin_sampler u_scl (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (scl_i),
        .level_o (scl_lvl),
        .rise_o  (scl_rise),
        .fall_o  (scl_fall)
    );

    rtr_pin_sampler u_sda (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (sda_i),
        .level_o (sda_lvl),
        .rise_o  (sda_rise),
        .fall_o  (sda_fall)
    );

    assign start_seen = scl_lvl & sda_fall & ~scl_fall;
    assign stop_seen  = scl_lvl & sda_rise & ~scl_rise;

    // ========================================================================
    // State
    rtr_state_type state, next_state;
    rtr_phase_type phase, next_phase;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] ptr, next_ptr;
    logic       rw, next_rw;
    logic       nack, next_nack;
    logic       sda_oe, next_sda_oe;
    logic [7:0] neg_adjust, next_neg_adjust;
    logic [7:0] bias_code, next_bias_code;
    logic [7:0] irq_enable, next_irq_enable;
    logic [7:0] flags, next_flags;
    logic [2:0] pos_level, next_pos_level;
    logic [7:0] bias_out, next_bias_out;
    logic [7:0] rd_data;
    logic [7:0] event_vec;
    logic       wr_en;
    logic       load_tx;
    logic       clear_flags;

    assign event_vec = {1'b0, overtemp_stop_evt_i, early_warn_evt_i,
                        therm_hot_evt_i, therm_cool_evt_i,
                        input_undervolt_evt_i, 2'b00};

    // ========================================================================
    // Read mux; unmapped offsets read zero
    always_comb begin
        case (ptr)
            REG_NEG_ADJUST: rd_data = neg_adjust & NEG_ADJUST_MASK;
            REG_BIAS_CODE:  rd_data = bias_code;
            REG_IRQ_ENABLE: rd_data = irq_enable & IRQ_FIELD_MASK;
            REG_IRQ_FLAGS:  rd_data = flags & IRQ_FIELD_MASK;
            default:        rd_data = 8'h00;
        endcase
    end

    // ========================================================================
    // Next-state logic
    always_comb begin
        next_state      = state;
        next_phase      = phase;
        next_bit_cnt    = bit_cnt;
        next_shift      = shift;
        next_ptr        = ptr;
        next_rw         = rw;
        next_nack       = nack;
        next_sda_oe     = sda_oe;
        next_neg_adjust = neg_adjust;
        next_bias_code  = bias_code;
        next_irq_enable = irq_enable;
        wr_en           = 1'b0;
        load_tx         = 1'b0;
        clear_flags     = 1'b0;

        if (stop_seen) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_seen) begin
            // Repeated start keeps the pointer for write-then-read
            next_state   = ST_RECV;
            next_phase   = PH_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        next_shift   = {shift[6:0], sda_lvl};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                        next_bit_cnt = 4'h0;
                        next_state   = ST_ACK;
                        next_sda_oe  = 1'b1;
                        case (phase)
                            PH_ADDR: begin
                                next_rw    = shift[0];
                                next_phase = PH_PTR;
                                if (shift[7:1] != DEV_ADDR) begin
                                    next_state  = ST_IDLE;
                                    next_sda_oe = 1'b0;
                                end
                            end
                            PH_PTR: begin
                                next_ptr   = shift;
                                next_phase = PH_DATA;
                            end
                            default: begin
                                wr_en    = 1'b1;
                                next_ptr = ptr + 8'h01;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        if (rw) begin
                            load_tx = 1'b1;
                        end else begin
                            next_state = ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (bit_cnt == BYTE_BITS) begin
                            next_sda_oe  = 1'b0;
                            next_bit_cnt = 4'h0;
                            next_state   = ST_MACK;
                        end else begin
                            next_sda_oe  = ~shift[7];
                            next_shift   = {shift[6:0], 1'b0};
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        next_nack = sda_lvl;
                    end else if (scl_fall) begin
                        if (nack) begin
                            next_state = ST_IDLE;
                        end else begin
                            load_tx = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state  = ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end

        // Byte out: first bit driven at once, pointer advances
        if (load_tx) begin
            next_state   = ST_SEND;
            next_sda_oe  = ~rd_data[7];
            next_shift   = {rd_data[6:0], 1'b0};
            next_bit_cnt = 4'h1;
            next_ptr     = ptr + 8'h01;
            clear_flags  = (ptr == REG_IRQ_FLAGS);
        end

        // Register writes
        if (wr_en) begin
            case (ptr)
                REG_NEG_ADJUST: begin
                    next_neg_adjust[SRC_SEL_BIT] = shift[SRC_SEL_BIT];
                    // Reserved trim codes are refused, field holds
                    if (shift[GATE_TRIM_MSB:GATE_TRIM_LSB] <= GATE_TRIM_MAX)
                        next_neg_adjust[GATE_TRIM_MSB:GATE_TRIM_LSB] =
                            shift[GATE_TRIM_MSB:GATE_TRIM_LSB];
                    if (shift[NEG_LEVEL_MSB:NEG_LEVEL_LSB] != NEG_LEVEL_RSVD)
                        next_neg_adjust[NEG_LEVEL_MSB:NEG_LEVEL_LSB] =
                            shift[NEG_LEVEL_MSB:NEG_LEVEL_LSB];
                end
                REG_BIAS_CODE: begin
                    next_bias_code = shift;
                end
                REG_IRQ_ENABLE: begin
                    next_irq_enable = shift & IRQ_FIELD_MASK;
                end
                default: begin
                    next_bias_code = bias_code;
                end
            endcase
        end

        // Enabled events set flags; a set in the clearing cycle wins
        next_flags = (clear_flags ? 8'h00 : flags)
                   | (event_vec & irq_enable & IRQ_FIELD_MASK);

        next_pos_level = neg_adjust[NEG_LEVEL_MSB:NEG_LEVEL_LSB];
        next_bias_out  = neg_adjust[SRC_SEL_BIT] ? bias_code
                                                 : ext_bias_code_i;
    end

    // ========================================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state      <= ST_IDLE;
            phase      <= PH_ADDR;
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            ptr        <= 8'h00;
            rw         <= 1'b0;
            nack       <= 1'b0;
            sda_oe     <= 1'b0;
            neg_adjust <= {BIAS_SRC_RESET, GATE_TRIM_RESET, 1'b0,
                           NEG_LEVEL_RESET};
            bias_code  <= BIAS_CODE_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
            flags      <= 8'h00;
            pos_level  <= NEG_LEVEL_RESET;
            bias_out   <= 8'h00;
        end else begin
            state      <= next_state;
            phase      <= next_phase;
            bit_cnt    <= next_bit_cnt;
            shift      <= next_shift;
            ptr        <= next_ptr;
            rw         <= next_rw;
            nack       <= next_nack;
            sda_oe     <= next_sda_oe;
            neg_adjust <= next_neg_adjust;
            bias_code  <= next_bias_code;
            irq_enable <= next_irq_enable;
            flags      <= next_flags;
            pos_level  <= next_pos_level;
            bias_out   <= next_bias_out;
        end
    end

    // Open drain: the data value is always low, only the enable moves
    always_ff @(posedge clk_i) begin
        sda_o <= 1'b0;
    end

    assign sda_oe_o                 = sda_oe;
    assign bias_source_select_o     = neg_adjust[SRC_SEL_BIT];
    assign gate_neg_trim_o          = neg_adjust[GATE_TRIM_MSB:GATE_TRIM_LSB];
    assign source_neg_level_o       = neg_adjust[NEG_LEVEL_MSB:NEG_LEVEL_LSB];
    assign source_pos_level_o       = pos_level;
    assign backplane_bias_code_o    = bias_out;
    assign overtemp_stop_irq_en_o   = irq_enable[OVERTEMP_BIT];
    assign early_warn_irq_en_o      = irq_enable[EARLY_WARN_BIT];
    assign therm_hot_irq_en_o       = irq_enable[THERM_HOT_BIT];
    assign therm_cool_irq_en_o      = irq_enable[THERM_COOL_BIT];
    assign input_undervolt_irq_en_o = irq_enable[UNDERVOLT_BIT];
    assign thermal_irq_flags_o      = flags;

    // ========================================================================
    // Assertions
    default clocking cb_main @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_reset_values: assert property (
        $past(reset_i) |-> neg_adjust == {BIAS_SRC_RESET, 7'h23}
            && bias_code == 8'h74 && irq_enable == 8'h74)
        else $error("register reset values wrong");
    chk_cool_en_reset: assert property (
        $past(reset_i) |-> !therm_cool_irq_en_o && therm_hot_irq_en_o)
        else $error("cooling enable reset value wrong");
    chk_trim_legal: assert property (
        gate_neg_trim_o <= 3'h4)
        else $error("gate trim holds a reserved code");
    chk_level_legal: assert property (
        source_neg_level_o != 3'h7)
        else $error("negative level holds a reserved code");
    chk_unused_zero: assert property (
        neg_adjust[3] == 1'b0 && irq_enable[7] == 1'b0
            && irq_enable[1:0] == 2'b00 && flags[7] == 1'b0)
        else $error("unused bit is not zero");
    chk_pos_follows: assert property (
        $changed(source_neg_level_o)
            |=> source_pos_level_o == $past(source_neg_level_o))
        else $error("positive level did not follow");
    chk_bias_mux: assert property (
        !$past(reset_i) |-> backplane_bias_code_o ==
            ($past(bias_source_select_o)
                ? $past(bias_code) : $past(ext_bias_code_i)))
        else $error("bias output source wrong");
    chk_overtemp_gate: assert property (
        overtemp_stop_evt_i && overtemp_stop_irq_en_o |=> flags[6])
        else $error("enabled overtemperature event lost");
    chk_warn_gate: assert property (
        $rose(flags[5]) |-> $past(early_warn_irq_en_o && early_warn_evt_i))
        else $error("early warning flag set while disabled");
    chk_hot_gate: assert property (
        $rose(flags[4]) |-> $past(therm_hot_irq_en_o))
        else $error("thermistor hot flag set while disabled");
    chk_uv_gate: assert property (
        $rose(flags[2]) |-> $past(input_undervolt_irq_en_o))
        else $error("undervoltage flag set while disabled");
    chk_bias_write: assert property (
        wr_en && ptr == REG_BIAS_CODE |=> bias_code == $past(shift))
        else $error("bias code write lost");
    chk_src_write: assert property (
        wr_en && ptr == REG_NEG_ADJUST
            |=> bias_source_select_o == $past(shift[7]))
        else $error("source select write lost");
    chk_idle_release: assert property (
        state == ST_IDLE |-> !sda_oe_o)
        else $error("data line driven while idle");

    cov_reg_write: cover property (wr_en && ptr == REG_NEG_ADJUST);
    cov_flag_read: cover property (load_tx && ptr == REG_IRQ_FLAGS);
    cov_pin_mode: cover property ($fell(bias_source_select_o));
    cov_burst_read: cover property (state == ST_MACK ##1 state == ST_SEND);
endmodule // rtr_rail_trim_regs

// file: rtr_host_model.sv
// I2C host model that reaches the register slice over SCL and SDA
`timescale 1ns/1ps
module rtr_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // ====================================================================
    // Bus phases; every change lands just after a rising edge
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic put_bit(input logic b);
        sda_o <= b;
        hold(5);
        scl_o <= 1'b1;
        hold(5);
        scl_o <= 1'b0;
        hold(1);
    endtask

    // Released line floats high through the pull-up
    task automatic get_bit(output logic b);
        sda_o <= 1'b1;
        hold(5);
        scl_o <= 1'b1;
        hold(3);
        b = sda_i;
        hold(2);
        scl_o <= 1'b0;
        hold(1);
    endtask

    task automatic start();
        sda_o <= 1'b1;
        hold(5);
        scl_o <= 1'b1;
        hold(5);
        sda_o <= 1'b0;
        hold(5);
        scl_o <= 1'b0;
        hold(1);
    endtask

    task automatic stop();
        sda_o <= 1'b0;
        hold(5);
        scl_o <= 1'b1;
        hold(5);
        sda_o <= 1'b1;
        hold(5);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(a);
        ack = ~a;
    endtask

    task automatic write_regs(input logic [6:0] addr,
                              input logic [7:0] ptr,
                              input logic [7:0] data [$],
                              output logic ok);
        logic a;
        start();
        send_byte({addr, 1'b0}, ok);
        send_byte(ptr, a);
        foreach (data[i]) begin
            send_byte(data[i], a);
        end
        stop();
    endtask

    // Single byte read ends with a not-acknowledge
    task automatic read_reg(input logic [6:0] addr,
                            input logic [7:0] ptr,
                            output logic [7:0] data,
                            output logic ok);
        logic a;
        start();
        send_byte({addr, 1'b0}, ok);
        send_byte(ptr, a);
        start();
        send_byte({addr, 1'b1}, a);
        for (int i = 7; i >= 0; i--) begin
            get_bit(data[i]);
        end
        put_bit(1'b1);
        stop();
    endtask
endmodule // rtr_host_model

// file: tb_rtr_rail_trim_regs.sv
// Self-checking bench for the rail trim register slice
`timescale 1ns/1ps
module tb_rtr_rail_trim_regs;
    import rtr_pkg::*;
    localparam logic [6:0] ADDR = 7'h20;
    logic       clk_i    = 1'b0;
    logic       reset_i  = 1'b1;
    logic       host_scl;
    logic       host_sda;
    logic       sda_o;
    logic       sda_oe_o;
    logic [7:0] ext_code = 8'h5A;
    logic [4:0] evt      = 5'h00;
    logic [4:0] en;
    logic [2:0] trim;
    logic [2:0] neg;
    logic [2:0] pos;
    logic [7:0] bias;
    logic [7:0] flags;
    logic       sel;
    logic       ok;
    int         miscompares = 0;
    int         comparisons = 0;
    int         cycles      = 0;
    wire        sda_line = host_sda & (sda_oe_o ? sda_o : 1'b1);

    always #5 clk_i = ~clk_i;

    rtr_host_model i_host (.clk_i(clk_i), .sda_i(sda_line),
        .scl_o(host_scl), .sda_o(host_sda));

    rtr_rail_trim_regs i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .scl_i(host_scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .ext_bias_code_i(ext_code),
        .overtemp_stop_evt_i(evt[4]), .early_warn_evt_i(evt[3]),
        .therm_hot_evt_i(evt[2]), .therm_cool_evt_i(evt[1]),
        .input_undervolt_evt_i(evt[0]), .bias_source_select_o(sel),
        .gate_neg_trim_o(trim), .source_neg_level_o(neg),
        .source_pos_level_o(pos), .backplane_bias_code_o(bias),
        .overtemp_stop_irq_en_o(en[4]), .early_warn_irq_en_o(en[3]),
        .therm_hot_irq_en_o(en[2]), .therm_cool_irq_en_o(en[1]),
        .input_undervolt_irq_en_o(en[0]), .thermal_irq_flags_o(flags));

    // ====================================================================
    // Shared checks and bus calls
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] got;
        i_host.read_reg(ADDR, ptr, got, ok);
        check({7'h00, ok}, 8'h01);
        check(got, exp);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
        i_host.write_regs(ADDR, ptr, d, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    task automatic pulse_events();
        evt <= 5'h1F;
        @(posedge clk_i);
        evt <= 5'h00;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // About 20 transfers of at most 443 cycles each, with wide margin
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            $display("ERROR at %0t: run did not finish", $time);
            results();
        end
    end

    // ====================================================================
    // Tests
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(REG_NEG_ADJUST, 8'hA3);
        rd(REG_BIAS_CODE, 8'h74);
        rd(REG_IRQ_ENABLE, 8'h74);
        rd(REG_IRQ_FLAGS, 8'h00);
        check(bias, 8'h74);
        check({5'h00, pos}, 8'h03);
        $display("test reset_values done");
        wr(REG_NEG_ADJUST, '{8'hFF});
        rd(REG_NEG_ADJUST, 8'hA3);
        wr(REG_NEG_ADJUST, '{8'h4E});
        rd(REG_NEG_ADJUST, 8'h46);
        check({1'b0, trim, 1'b0, neg}, 8'h46);
        check({5'h00, pos}, 8'h06);
        check(bias, 8'h5A);
        ext_code <= 8'hC3;
        repeat (3) @(posedge clk_i);
        check(bias, 8'hC3);
        $display("test neg_adjust done");
        wr(REG_BIAS_CODE, '{8'hFF, 8'h28});
        rd(REG_BIAS_CODE, 8'hFF);
        rd(REG_IRQ_ENABLE, 8'h28);
        check({3'h0, en}, 8'h0A);
        check(bias, 8'hC3);
        wr(REG_NEG_ADJUST, '{8'hC6});
        check({7'h00, sel}, 8'h01);
        check(bias, 8'hFF);
        $display("test burst_and_select done");
        pulse_events();
        check(flags, 8'h28);
        rd(REG_IRQ_FLAGS, 8'h28);
        rd(REG_IRQ_FLAGS, 8'h00);
        wr(REG_IRQ_ENABLE, '{8'hFF});
        rd(REG_IRQ_ENABLE, 8'h7C);
        pulse_events();
        rd(REG_IRQ_FLAGS, 8'h7C);
        $display("test event_flags done");
        rd(8'h10, 8'h00);
        i_host.write_regs(7'h21, REG_BIAS_CODE, '{8'h00}, ok);
        check({7'h00, ok}, 8'h00);
        rd(REG_BIAS_CODE, 8'hFF);
        $display("test refusals done");
        results();
    end
endmodule // tb_rtr_rail_trim_regs
